// *** hw/crdc_defines.vh ***
// Register offsets, field positions and reset values of the clock receiver and delay control bank.
`ifndef CRDC_DEFINES_VH
`define CRDC_DEFINES_VH
`define CRDC_ADDR_TRIM_NEG 8'h31
`define CRDC_ADDR_RX_CTRL 8'h32
`define CRDC_ADDR_DLY_CTRL 8'h33
`define CRDC_ADDR_BIAS 8'h36
`define CRDC_ADDR_DLY_LO 8'h39
`define CRDC_ADDR_DLY_HI 8'h3a
`define CRDC_RST_TRIM_NEG 8'h00
`define CRDC_RST_RX_CTRL 8'h00
`define CRDC_RST_DLY_CTRL 8'h00
`define CRDC_RST_BIAS 8'h00
`define CRDC_MASK_TRIM_NEG 8'hf0
`define CRDC_MASK_BIAS 8'h83
`define CRDC_BIT_RX_EN 7
`define CRDC_BIT_FACTORY 6
`define CRDC_BIT_POS_SIGN 5
`define CRDC_BIT_NEG_SIGN 0
`define CRDC_BIT_CLK_GATE 7
`define CRDC_BIT_SLOPE 6
`define CRDC_BIT_SAMPLE 3
`define CRDC_BIT_CTRL_EN 0
`define CRDC_BIT_BIAS_POWER_DOWN 7
`define CRDC_MODE_SEARCH_TRACK 2'h0
`define CRDC_MODE_TRACK 2'h1
`define CRDC_MODE_SEARCH 2'h2
`define CRDC_GAIN_INVALID 2'h3
`define CRDC_PHASE_MAX 5'h10
`endif

// *** hw/crdc_regs.v ***
// Configuration register bank for the clock receiver, delay-lock controller and bias.
`timescale 1ns/10ps
`include "crdc_defines.vh"
module crdc_regs #(
	parameter DLY_W = 9,
	parameter PHZ_W = 5
) (
	input wire core_clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire wr_en_in,
	input wire [7:0] addr_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	input wire [DLY_W-1:0] locked_dly_in,
	input wire [PHZ_W-1:0] locked_phz_in,
	input wire measured_slope_in,
	output wire clock_receiver_enable_out,
	output wire [3:0] neg_input_cm_trim_out,
	output wire [3:0] pos_input_cm_trim_out,
	output wire pos_trim_sign_out,
	output wire neg_trim_sign_out,
	output wire delay_ctrl_clock_run_out,
	output wire slope_match_out,
	output wire search_en_out,
	output wire track_en_out,
	output wire [1:0] track_gain_out,
	output wire delay_ctrl_enable_out,
	output wire bias_power_down_out,
	output wire [1:0] mirror_bandwidth_select_out,
	output wire mirror_rolloff_bypass_out,
	output wire phase_over_limit_out
);
	localparam [7:0] TRIM_MASK = `CRDC_MASK_TRIM_NEG;
	localparam [7:0] BIAS_MASK = `CRDC_MASK_BIAS;
	localparam [7:0] RX_RST = `CRDC_RST_RX_CTRL;

	reg [7:0] trim_neg_r;
	reg [7:0] rx_ctrl_r;
	reg [7:0] dly_ctrl_r;
	reg [7:0] bias_r;
	reg [7:0] trim_neg_nxt;
	reg [7:0] rx_ctrl_nxt;
	reg [7:0] dly_ctrl_nxt;
	reg [7:0] bias_nxt;
	reg [7:0] rdata_nxt;
	reg search_en_c;
	reg track_en_c;
	reg [1:0] gain_c;
	wire [7:0] trim_wdata;
	wire [7:0] rx_wdata;
	wire [7:0] bias_wdata;
	wire wr_trim;
	wire wr_rx;
	wire wr_dly;
	wire wr_bias;
	wire [DLY_W-1:0] cap_dly;
	wire [PHZ_W-1:0] cap_phz;
	wire [1:0] mode;
	wire [1:0] gain;

	// A write is taken only on an enabled edge, so a frozen bank also ignores the bus.
	assign wr_trim = ce_in && wr_en_in && (addr_in == `CRDC_ADDR_TRIM_NEG);
	assign wr_rx = ce_in && wr_en_in && (addr_in == `CRDC_ADDR_RX_CTRL);
	assign wr_dly = ce_in && wr_en_in && (addr_in == `CRDC_ADDR_DLY_CTRL);
	assign wr_bias = ce_in && wr_en_in && (addr_in == `CRDC_ADDR_BIAS);

	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1) begin : g_wmask
			assign trim_wdata[b] = TRIM_MASK[b] ? wdata_in[b] : 1'b0;
			assign bias_wdata[b] = BIAS_MASK[b] ? wdata_in[b] : 1'b0;
			// The factory bit is not writable, so a careless write cannot disturb it.
			assign rx_wdata[b] = (b == `CRDC_BIT_FACTORY) ? RX_RST[b] : wdata_in[b];
		end
	endgenerate

	always @* begin
		trim_neg_nxt = trim_neg_r;
		rx_ctrl_nxt = rx_ctrl_r;
		dly_ctrl_nxt = dly_ctrl_r;
		bias_nxt = bias_r;
		if (wr_trim) begin
			trim_neg_nxt = trim_wdata;
		end
		if (wr_rx) begin
			rx_ctrl_nxt = rx_wdata;
		end
		if (wr_dly) begin
			dly_ctrl_nxt = wdata_in;
		end
		if (wr_bias) begin
			bias_nxt = bias_wdata;
		end
	end

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			trim_neg_r <= `CRDC_RST_TRIM_NEG;
			rx_ctrl_r <= `CRDC_RST_RX_CTRL;
			dly_ctrl_r <= `CRDC_RST_DLY_CTRL;
			bias_r <= `CRDC_RST_BIAS;
		end else if (ce_in) begin
			trim_neg_r <= trim_neg_nxt;
			rx_ctrl_r <= rx_ctrl_nxt;
			dly_ctrl_r <= dly_ctrl_nxt;
			bias_r <= bias_nxt;
		end
	end

	crdc_sample #(
		.DLY_W(DLY_W),
		.PHZ_W(PHZ_W)
	) u_sample (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.strobe_in(dly_ctrl_r[`CRDC_BIT_SAMPLE]),
		.dly_in(locked_dly_in),
		.phz_in(locked_phz_in),
		.dly_out(cap_dly),
		.phz_out(cap_phz)
	);

	// Captured delay and phase share the layout of the neighbouring delay registers.
	always @* begin
		rdata_nxt = 8'h00;
		case (addr_in)
			`CRDC_ADDR_TRIM_NEG: rdata_nxt = trim_neg_r;
			`CRDC_ADDR_RX_CTRL: rdata_nxt = rx_ctrl_r;
			`CRDC_ADDR_DLY_CTRL: rdata_nxt = dly_ctrl_r;
			`CRDC_ADDR_BIAS: rdata_nxt = bias_r;
			`CRDC_ADDR_DLY_LO: rdata_nxt = {cap_dly[0], 2'b00, cap_phz};
			`CRDC_ADDR_DLY_HI: rdata_nxt = cap_dly[8:1];
			default: rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge core_clk_in) begin
		if (rst_in) begin
			rdata_out <= 8'h00;
		end else if (ce_in) begin
			rdata_out <= rdata_nxt;
		end
	end

	assign clock_receiver_enable_out = rx_ctrl_r[`CRDC_BIT_RX_EN];
	assign neg_input_cm_trim_out = trim_neg_r[7:4];
	assign pos_input_cm_trim_out = rx_ctrl_r[4:1];
	assign pos_trim_sign_out = rx_ctrl_r[`CRDC_BIT_POS_SIGN];
	assign neg_trim_sign_out = rx_ctrl_r[`CRDC_BIT_NEG_SIGN];
	assign delay_ctrl_clock_run_out = ~dly_ctrl_r[`CRDC_BIT_CLK_GATE];
	assign slope_match_out = measured_slope_in == dly_ctrl_r[`CRDC_BIT_SLOPE];
	assign mode = dly_ctrl_r[5:4];
	assign gain = dly_ctrl_r[2:1];

	always @* begin
		search_en_c = 1'b0;
		track_en_c = 1'b0;
		case (mode)
			`CRDC_MODE_SEARCH_TRACK: begin
				search_en_c = 1'b1;
				track_en_c = 1'b1;
			end
			`CRDC_MODE_TRACK: begin
				track_en_c = 1'b1;
			end
			`CRDC_MODE_SEARCH: begin
				search_en_c = 1'b1;
			end
			default: begin
				search_en_c = 1'b0;
				track_en_c = 1'b0;
			end
		endcase
	end
	assign search_en_out = search_en_c;
	assign track_en_out = track_en_c;

	// invalid gain falls back
	// Slowest tracking is the safe choice when the code is unusable; it may lag but never runs away.
	always @* begin
		gain_c = gain;
		if (gain == `CRDC_GAIN_INVALID) begin
			gain_c = 2'h0;
		end
	end
	assign track_gain_out = gain_c;
	assign delay_ctrl_enable_out = dly_ctrl_r[`CRDC_BIT_CTRL_EN];
	assign bias_power_down_out = bias_r[`CRDC_BIT_BIAS_POWER_DOWN];
	assign mirror_bandwidth_select_out = bias_r[1:0];
	assign mirror_rolloff_bypass_out = bias_r[1:0] == 2'h0;
	assign phase_over_limit_out = cap_phz > `CRDC_PHASE_MAX;
endmodule

// *** hw/crdc_sample.v ***
// Rising-edge capture of the locked delay and phase for readback.
`timescale 1ns/10ps
module crdc_sample #(
	parameter DLY_W = 9,
	parameter PHZ_W = 5
) (
	input wire core_clk_in,
	input wire rst_in,
	input wire ce_in,
	input wire strobe_in,
	input wire [DLY_W-1:0] dly_in,
	input wire [PHZ_W-1:0] phz_in,
	output reg [DLY_W-1:0] dly_out,
	output reg [PHZ_W-1:0] phz_out
);
	reg strobe_r;
	always @(posedge core_clk_in) begin
		if (rst_in) begin
			strobe_r <= 1'b0;
			dly_out <= {DLY_W{1'b0}};
			phz_out <= {PHZ_W{1'b0}};
		end else if (ce_in) begin
			strobe_r <= strobe_in;
			if (strobe_in && !strobe_r) begin
				dly_out <= dly_in;
				phz_out <= phz_in;
			end
		end
	end
endmodule

// *** testbench/crdc_regs_asserts.sv ***
// Port checker for the clock receiver and delay control register bank.
`timescale 1ns/10ps
module crdc_regs_asserts (
	input core_clk_in, rst_in, ce_in, wr_en_in, measured_slope_in,
	input [7:0] addr_in, wdata_in,
	input clock_receiver_enable_out, pos_trim_sign_out, neg_trim_sign_out,
	input delay_ctrl_clock_run_out, slope_match_out, search_en_out, track_en_out,
	input [1:0] track_gain_out, mirror_bandwidth_select_out,
	input bias_power_down_out, mirror_rolloff_bypass_out
);
	wire we = ce_in && wr_en_in;
	wire w32 = we && addr_in == 8'h32;
	wire w33 = we && addr_in == 8'h33;
	wire w36 = we && addr_in == 8'h36;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_rx_reset_off: assert property (disable iff (1'b0)
		rst_in && ce_in |=> !clock_receiver_enable_out) else $error("rx on after reset");
	a_gate_bit: assert property (w33 |=> delay_ctrl_clock_run_out == !$past(wdata_in[7]))
		else $error("gate bit");
	a_slope_cmp: assert property (w33 |=>
		slope_match_out == (measured_slope_in == $past(wdata_in[6]))) else $error("slope");
	a_mode_decode: assert property (w33 |=>
		{track_en_out, search_en_out} == ~$past(wdata_in[5:4])) else $error("mode");
	a_gain_map: assert property (w33 |=> track_gain_out ==
		(&$past(wdata_in[2:1]) ? 2'h0 : $past(wdata_in[2:1]))) else $error("gain");
	a_bias_pd: assert property (w36 |=> bias_power_down_out == $past(wdata_in[7]))
		else $error("bias");
	a_mirror_sel: assert property (w36 |=> mirror_bandwidth_select_out == $past(wdata_in[1:0])
		&& mirror_rolloff_bypass_out == ($past(wdata_in[1:0]) == 2'h0)) else $error("mirror");
	a_trim_signs: assert property (w32 |=> pos_trim_sign_out == $past(wdata_in[5])
		&& neg_trim_sign_out == $past(wdata_in[0])) else $error("signs");
endmodule
bind crdc_regs crdc_regs_asserts u_asserts (.*);

// *** testbench/tb_crdc_regs.sv ***
// Self-checking bench for the clock receiver and delay control register bank.
`timescale 1ns/10ps
module tb_crdc_regs;
	reg clk = 0, rst = 1, wr = 0, rv = 0, rvd = 0, slope = 0, ce = 1;
	wire [3:0] ntrim, ptrim;
	wire [1:0] gain;
	wire ctl_en, pd, over;
	// delay 431, phase 14 as advised
	reg [7:0] a = 0, d = 0, ad, dt;
	reg [8:0] dly = 9'h1af;
	reg [4:0] phz = 5'h0e;
	reg [31:0] s = 32'he8ef2e30, mk;
	reg [7:0] q[$];
	integer error_cnt = 0, n_tests = 0, cyc = 0, i;
	wire [7:0] rd;
	wire rx_en;
	always #5 clk = ~clk;
	crdc_regs DUT (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .wr_en_in(wr), .addr_in(a),
		.wdata_in(d), .rdata_out(rd), .locked_dly_in(dly), .locked_phz_in(phz),
		.measured_slope_in(slope), .clock_receiver_enable_out(rx_en),
		.neg_input_cm_trim_out(ntrim), .pos_input_cm_trim_out(ptrim), .pos_trim_sign_out(),
		.neg_trim_sign_out(), .delay_ctrl_clock_run_out(), .slope_match_out(),
		.search_en_out(), .track_en_out(), .track_gain_out(gain), .delay_ctrl_enable_out(ctl_en),
		.bias_power_down_out(pd), .mirror_bandwidth_select_out(), .mirror_rolloff_bypass_out(),
		.phase_over_limit_out(over));
	function [31:0] xs(input [31:0] x);
		begin
			x = x ^ (x << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction
	task check(input [7:0] seen, input [7:0] exp, input string nm);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("BAD %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// The idle edge after each write keeps the strobe from being assigned twice in one step.
	task put(input [7:0] ra, input [7:0] rdt);
		begin
			a <= ra;
			d <= rdt;
			wr <= 1;
			@(posedge clk);
			wr <= 0;
			@(posedge clk);
		end
	endtask
	task get(input [7:0] ra, input [7:0] e);
		begin
			a <= ra;
			q.push_back(e);
			rv <= 1;
			@(posedge clk);
			rv <= 0;
			@(posedge clk);
		end
	endtask
	task tally_and_finish;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		rvd <= rv;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			tally_and_finish;
		end
	end
	always @(negedge clk) begin
		if (rvd)
			check(rd, q.pop_front(), "rdata");
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		check({7'h0, rx_en}, 8'h00, "rx_en");
		get(8'h32, 8'h00);
		$display("reset test done");
		for (i = 0; i < 16; i = i + 1) begin
			s = xs(s);
			ad = (i[1:0] == 2'h3) ? 8'h36 : 8'h31 + {6'h0, i[1:0]};
			mk = 32'h83ffbff0 >> {i[1:0], 3'b0};
			dt = s[7:0];
			if (i[1:0] == 2'h1)
				dt[6] = 1'b0;
			slope <= s[8];
			put(ad, dt);
			get(ad, dt & mk[7:0]);
		end
		$display("register test done");
		put(8'h33, 8'h00);
		put(8'h33, 8'h08);
		repeat (2) @(posedge clk);
		dly <= 9'h0d8;
		phz <= 5'h10;
		put(8'h33, 8'h08);
		put(8'h39, 8'h00);
		get(8'h39, 8'h8e);
		get(8'h3a, 8'hd7);
		// phase 16 is legal and must not raise the flag
		put(8'h33, 8'h00);
		put(8'h33, 8'h08);
		get(8'h39, 8'h10);
		get(8'h3a, 8'h6c);
		check({7'h0, over}, 8'h00, "phase_over_limit");
		$display("capture test done");
		// boost and duty correction sit outside this bank and count as on here
		// the bench clock is already stable when the receiver is enabled
		put(8'h31, 8'hf0);
		put(8'h32, 8'h9e);
		check({4'h0, ntrim}, 8'h0f, "neg_trim");
		check({4'h0, ptrim}, 8'h0f, "pos_trim");
		check({7'h0, rx_en}, 8'h01, "rx_en");
		put(8'h33, 8'h43);
		check({7'h0, ctl_en}, 8'h01, "ctrl_en");
		check({6'h0, gain}, 8'h01, "gain");
		put(8'h33, 8'h46);
		check({6'h0, gain}, 8'h00, "gain_invalid");
		check({7'h0, ctl_en}, 8'h00, "ctrl_off");
		ce <= 0;
		put(8'h36, 8'h80);
		check({7'h0, pd}, 8'h00, "frozen_pd");
		ce <= 1;
		put(8'h36, 8'h80);
		check({7'h0, pd}, 8'h01, "bias_pd");
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		get(8'h32, 8'h00);
		get(8'h36, 8'h00);
		$display("setup test done");
		tally_and_finish;
	end
endmodule
